//--- logic/quad_dac_update_control.sv
`timescale 1ns/1ps
`default_nettype none
module quad_dac_update_control (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // byte stream from the serial front end
    input wire logic frameStart,
    input wire logic frameEnd,
    input wire logic byteStrobe,
    input wire logic [7:0] byteData,
    // pins
    input wire logic ext_addr_pin_hi,
    input wire logic ext_addr_pin_lo,
    input wire logic async_load_pin,
    // readback
    input wire logic [1:0] readSel,
    output logic [13:0] readData,
    // channel registers, channel A in the low bits
    output logic [55:0] dacOut,
    output logic [55:0] tempOut,
    output logic frameActive
);
    typedef enum logic [1:0] {IDLE, GET_CTRL, GET_HIGH, GET_LOW}
        seq_state_e;

    seq_state_e state;
    logic [7:0] control_byte_reg;
    logic [7:0] high_data_byte_reg;
    logic [7:0] low_data_byte_reg;
    logic pdLock;
    logic commit;
    logic loadPinPrev;
    logic asyncCopy;

    update_if upd ();

    // ------------------------------------------------
    // byte sequencing
    // ------------------------------------------------
    // a stop or repeated start always ends the current stream
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state <= IDLE;
        else if (frameEnd)
            state <= IDLE;
        else if (frameStart)
            state <= GET_CTRL;
        else if (byteStrobe)
        begin
            unique case (state)
                IDLE: state <= IDLE;
                GET_CTRL: state <= GET_HIGH;
                GET_HIGH: state <= GET_LOW;
                // after power-down data, further bytes are dropped
                GET_LOW: state <= pdLock ? IDLE : GET_HIGH;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            control_byte_reg <= 8'h00;
            pdLock <= 1'b0;
        end
        else if (byteStrobe && state == GET_CTRL && !frameStart && !frameEnd)
        begin
            control_byte_reg <= byteData;
            pdLock <= byteData[quad_dac_pkg::PD_FLAG_POS];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            high_data_byte_reg <= 8'h00;
        else if (byteStrobe && state == GET_HIGH && !frameStart && !frameEnd)
            high_data_byte_reg <= byteData;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            low_data_byte_reg <= 8'h00;
        else if (commit)
            low_data_byte_reg <= byteData;
    end

    // strobe marks the acknowledge falling edge after the byte
    assign commit = byteStrobe && state == GET_LOW && !frameStart &&
        !frameEnd;

    // ------------------------------------------------
    // asynchronous load pin
    // ------------------------------------------------
    // pin taken as synchronous; a level held high acts only once
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            loadPinPrev <= 1'b0;
        else
            loadPinPrev <= async_load_pin;
    end

    assign asyncCopy = async_load_pin && !loadPinPrev;

    // ------------------------------------------------
    // decode and register bank
    // ------------------------------------------------
    ctrl_decode u_decode (
        .commit(commit),
        .asyncCopy(asyncCopy),
        .ctrlByte(control_byte_reg),
        .hiByte(high_data_byte_reg),
        .loByte(byteData),
        .extAddr({ext_addr_pin_hi, ext_addr_pin_lo}),
        .upd(upd.dec)
    );

    channel_bank u_bank (
        .clk_sys(clk_sys),
        .rst(rst),
        .upd(upd.bank),
        .tempOut(tempOut),
        .dacOut(dacOut)
    );

    // ------------------------------------------------
    // readback
    // ------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            readData <= quad_dac_pkg::WORD_RESET;
        else
            readData <= tempOut[readSel*14 +: 14];
    end

    assign frameActive = (state != IDLE);
endmodule : quad_dac_update_control
`default_nettype wire

//--- logic/quad_dac_pkg.sv
// Overview of operation
// - mode 00: selected temporary register only
// - mode 01: selected temporary and output register
// - mode 10: selected channel new, others from temporary
// - broadcast acts without address match, ignores channel
// - broadcast, select high 0: all outputs from temporary
// - broadcast, select high 1: all channels new data
// - broadcast, select high 1, flag 1: all power down
// - first data byte is upper eight bits
// - flag set: high byte bits 7-6 are code
// - low byte upper nibble is low data
// - update at acknowledge after low byte
// - readback register cleared at reset
// - async load edge copies all temporaries
// - 14-bit temporary register per channel
// - 14-bit output register per channel
// - control byte field layout latched
// - repeated data pairs until stop, flag clear only
package quad_dac_pkg;
    localparam int NUM_CH = 4;
    localparam int WORD_W = 14;
    localparam int DATA_W = 12;
    // control byte fields
    localparam int ADDR_HI_POS = 7;
    localparam int ADDR_LO_POS = 6;
    localparam int MODE_HI_POS = 5;
    localparam int MODE_LO_POS = 4;
    localparam int SEL_HI_POS = 2;
    localparam int SEL_LO_POS = 1;
    localparam int PD_FLAG_POS = 0;
    // high byte power-down code field
    localparam int PD_CODE_HI_POS = 7;
    localparam int PD_CODE_LO_POS = 6;
    // update modes
    localparam logic [1:0] MODE_TEMP = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_SYNC = 2'h2;
    localparam logic [1:0] MODE_BCAST = 2'h3;
    localparam logic [WORD_W-1:0] WORD_RESET = 14'h0000;

    function automatic logic [NUM_CH-1:0] chanOneHot(input logic [1:0] sel);
        chanOneHot = 4'h1 << sel;
    endfunction : chanOneHot

    // power-down code above twelve data bits
    function automatic logic [WORD_W-1:0] buildWord(
        input logic pdFlag,
        input logic [7:0] hiByte,
        input logic [7:0] loByte
    );
        if (pdFlag)
            buildWord = {hiByte[PD_CODE_HI_POS], hiByte[PD_CODE_LO_POS],
                12'h000};
        else
            buildWord = {2'h0, hiByte, loByte[7:4]};
    endfunction : buildWord
endpackage : quad_dac_pkg

//--- logic/update_if.sv
`timescale 1ns/1ps
`default_nettype none
interface update_if;
    logic [3:0] loadTemp;
    logic [3:0] loadDac;
    logic [3:0] copyTemp;
    logic [13:0] word;
    modport dec (output loadTemp, output loadDac, output copyTemp,
        output word);
    modport bank (input loadTemp, input loadDac, input copyTemp,
        input word);
endinterface : update_if
`default_nettype wire

//--- logic/ctrl_decode.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_decode (
    // decoded command
    input wire logic commit,
    input wire logic asyncCopy,
    input wire logic [7:0] ctrlByte,
    input wire logic [7:0] hiByte,
    input wire logic [7:0] loByte,
    input wire logic [1:0] extAddr,
    // steering to the bank
    update_if.dec upd
);
    logic [1:0] mode;
    logic [1:0] sel;
    logic pdFlag;
    logic addrOk;
    logic [3:0] selHot;

    assign mode = {ctrlByte[quad_dac_pkg::MODE_HI_POS],
        ctrlByte[quad_dac_pkg::MODE_LO_POS]};
    assign sel = {ctrlByte[quad_dac_pkg::SEL_HI_POS],
        ctrlByte[quad_dac_pkg::SEL_LO_POS]};
    assign pdFlag = ctrlByte[quad_dac_pkg::PD_FLAG_POS];
    assign selHot = quad_dac_pkg::chanOneHot(sel);
    assign addrOk = (mode == quad_dac_pkg::MODE_BCAST) ||
        ({ctrlByte[quad_dac_pkg::ADDR_HI_POS],
        ctrlByte[quad_dac_pkg::ADDR_LO_POS]} == extAddr);
    assign upd.word = quad_dac_pkg::buildWord(pdFlag, hiByte, loByte);

    always_comb
    begin
        upd.loadTemp = 4'h0;
        upd.loadDac = 4'h0;
        upd.copyTemp = asyncCopy ? 4'hF : 4'h0;
        if (commit && addrOk)
        begin
            unique case (mode)
                quad_dac_pkg::MODE_TEMP:
                    upd.loadTemp = selHot;
                quad_dac_pkg::MODE_SINGLE:
                begin
                    upd.loadTemp = selHot;
                    upd.loadDac = selHot;
                end
                quad_dac_pkg::MODE_SYNC:
                begin
                    upd.loadTemp = selHot;
                    upd.loadDac = selHot;
                    upd.copyTemp = 4'hF;
                end
                quad_dac_pkg::MODE_BCAST:
                begin
                    if (sel[1])
                    begin
                        upd.loadTemp = 4'hF;
                        upd.loadDac = 4'hF;
                    end
                    else
                        upd.copyTemp = 4'hF;
                end
            endcase
        end
    end
endmodule : ctrl_decode
`default_nettype wire

//--- logic/channel_bank.sv
`timescale 1ns/1ps
`default_nettype none
module channel_bank (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // steering
    update_if.bank upd,
    // register contents, channel A in the low bits
    output logic [55:0] tempOut,
    output logic [55:0] dacOut
);
    genvar ch;
    generate
        for (ch = 0; ch < quad_dac_pkg::NUM_CH; ch++)
        begin : g_ch
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                    tempOut[ch*14 +: 14] <= quad_dac_pkg::WORD_RESET;
                else if (upd.loadTemp[ch])
                    tempOut[ch*14 +: 14] <= upd.word;
            end
            // direct load beats copy; copy reads the old temporary
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                    dacOut[ch*14 +: 14] <= quad_dac_pkg::WORD_RESET;
                else if (upd.loadDac[ch])
                    dacOut[ch*14 +: 14] <= upd.word;
                else if (upd.copyTemp[ch])
                    dacOut[ch*14 +: 14] <= tempOut[ch*14 +: 14];
            end
        end
    endgenerate
endmodule : channel_bank
`default_nettype wire

//--- bench/quad_dac_update_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module quad_dac_update_control_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // byte stream and pins
    input wire logic frameStart,
    input wire logic frameEnd,
    input wire logic byteStrobe,
    input wire logic [7:0] byteData,
    input wire logic ext_addr_pin_hi,
    input wire logic ext_addr_pin_lo,
    input wire logic async_load_pin,
    // observed state
    input wire logic [1:0] readSel,
    input wire logic [13:0] readData,
    input wire logic [55:0] dacOut,
    input wire logic [55:0] tempOut,
    input wire logic frameActive
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // write sequence steps
    // ----------------------------------------
    sequence sCtrlSingle;
        frameStart && !frameEnd ##1 byteStrobe && byteData[5:0] == 6'h10
        && byteData[7:6] == {ext_addr_pin_hi, ext_addr_pin_lo};
    endsequence
    sequence sPair;
        byteStrobe [*2];
    endsequence
    AST_SINGLE: assert property (sCtrlSingle ##1 sPair |=>
        tempOut[13:0] == {2'h0, $past(byteData, 2), $past(byteData[7:4])}
        && dacOut[13:0] == tempOut[13:0])
        else $error("single write wrong");
    AST_RST: assert property (disable iff (1'b0) rst |=>
        dacOut == 56'h0 && tempOut == 56'h0 && readData == 14'h0)
        else $error("reset value wrong");
    AST_ASYNC: assert property (
        $rose(async_load_pin) && !byteStrobe |=> dacOut == $past(tempOut))
        else $error("async copy wrong");
    AST_FRAME: assert property (
        frameStart && !frameEnd |=> frameActive)
        else $error("frame not opened");
    AST_END: assert property (frameEnd |=> !frameActive)
        else $error("frame not closed");
    AST_READ: assert property (1'b1 |=> readData ==
        14'($past(tempOut) >> (14 * $past(readSel))))
        else $error("readback wrong");
    AST_TEMPHOLD: assert property (!byteStrobe |=> $stable(tempOut))
        else $error("temp changed without byte");
    AST_DACHOLD: assert property (
        !byteStrobe && !$rose(async_load_pin) |=> $stable(dacOut))
        else $error("output changed without cause");
endmodule : quad_dac_update_control_chk
`default_nettype wire

//--- bench/byte_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module byte_master_model (
    // clock
    input wire logic clk_sys,
    // byte stream
    output logic frameStart,
    output logic frameEnd,
    output logic byteStrobe,
    output logic [7:0] byteData
);
    initial
    begin
        frameStart = 1'b0;
        frameEnd = 1'b0;
        byteStrobe = 1'b0;
        byteData = 8'h5A;
    end
    // one cycle of the stream, entered at a falling edge
    task automatic put(input logic s, input logic b, input logic e,
        input logic [7:0] d);
        frameStart = s;
        byteStrobe = b;
        frameEnd = e;
        // idle data line toggles so a stale byte is never reused
        byteData = b ? d : ~byteData;
        @(negedge clk_sys);
    endtask : put
endmodule : byte_master_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys, rst, asyncLoad, frameStart, frameEnd, byteStrobe;
    logic frameActive;
    logic [1:0] readSel;
    logic [7:0] byteData;
    logic [13:0] readData;
    logic [55:0] dacOut, tempOut;
    logic [13:0] expT [4];
    logic [13:0] expD [4];
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    byte_master_model i_mst (.clk_sys(clk_sys), .frameStart(frameStart),
        .frameEnd(frameEnd), .byteStrobe(byteStrobe), .byteData(byteData));
    // address pins fixed at 01, so local control bytes carry 0x40
    quad_dac_update_control i_dut (.clk_sys(clk_sys), .rst(rst),
        .frameStart(frameStart), .frameEnd(frameEnd),
        .byteStrobe(byteStrobe), .byteData(byteData),
        .ext_addr_pin_hi(1'b0), .ext_addr_pin_lo(1'b1),
        .async_load_pin(asyncLoad), .readSel(readSel),
        .readData(readData), .dacOut(dacOut), .tempOut(tempOut),
        .frameActive(frameActive));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic stop_test();
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic chkAll();
        for (int i = 0; i < 4; i++)
        begin
            readSel = 2'(i);
            @(negedge clk_sys);
            @(negedge clk_sys);
            chk(tempOut[14*i +: 14], expT[i]);
            chk(dacOut[14*i +: 14], expD[i]);
            chk(readData, expT[i]);
        end
    endtask : chkAll
    function automatic logic [13:0] wd(input logic [7:0] h,
        input logic [7:0] l);
        return {2'h0, h, l[7:4]};
    endfunction : wd
    task automatic setAll(input logic [13:0] t, input logic [13:0] d,
        input logic cp);
        for (int i = 0; i < 4; i++)
        begin
            expT[i] = cp ? expT[i] : t;
            expD[i] = cp ? expT[i] : d;
        end
    endtask : setAll
    task automatic wr(input logic [7:0] c, input logic [7:0] h,
        input logic [7:0] l, input logic two);
        i_mst.put(1'b1, 1'b0, 1'b0, 8'h00);
        i_mst.put(1'b0, 1'b1, 1'b0, c);
        i_mst.put(1'b0, 1'b1, 1'b0, h);
        i_mst.put(1'b0, 1'b1, 1'b0, l);
        if (two)
        begin
            i_mst.put(1'b0, 1'b1, 1'b0, ~h);
            i_mst.put(1'b0, 1'b1, 1'b0, ~l);
        end
        i_mst.put(1'b0, 1'b0, 1'b1, 8'h00);
        i_mst.put(1'b0, 1'b0, 1'b0, 8'h00);
    endtask : wr
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic tLocal();
        wr(8'h44, 8'h12, 8'h3F, 1'b0);
        expT[2] = 14'h0123;
        chkAll();
        wr(8'h50, 8'h21, 8'h4C, 1'b1);
        expT[0] = wd(8'hDE, 8'hB3);
        expD[0] = expT[0];
        chkAll();
        wr(8'h66, 8'hFE, 8'hD0, 1'b0);
        expT[3] = 14'h0FED;
        setAll(14'h0, 14'h0, 1'b1);
        chkAll();
    endtask : tLocal
    task automatic tAddr();
        wr(8'h92, 8'h55, 8'h50, 1'b0);
        chkAll();
        wr(8'h53, 8'h80, 8'h00, 1'b0);
        expT[1] = 14'h2000;
        expD[1] = 14'h2000;
        chkAll();
        // bytes after a power-down pair are dropped
        wr(8'h41, 8'h40, 8'h00, 1'b1);
        expT[0] = 14'h1000;
        chkAll();
        // frame cut before the low byte, then a stray strobe
        i_mst.put(1'b1, 1'b0, 1'b0, 8'h00);
        i_mst.put(1'b0, 1'b1, 1'b0, 8'h50);
        i_mst.put(1'b0, 1'b1, 1'b0, 8'h99);
        i_mst.put(1'b0, 1'b0, 1'b1, 8'h00);
        i_mst.put(1'b0, 1'b1, 1'b0, 8'h88);
        i_mst.put(1'b0, 1'b0, 1'b0, 8'h00);
        chkAll();
    endtask : tAddr
    task automatic tBcast();
        wr(8'hF4, 8'hA5, 8'h5A, 1'b0);
        setAll(14'h0A55, 14'h0A55, 1'b0);
        chkAll();
        wr(8'h40, 8'h33, 8'h30, 1'b0);
        expT[0] = 14'h0333;
        wr(8'hF0, 8'h00, 8'h00, 1'b0);
        setAll(14'h0, 14'h0, 1'b1);
        chkAll();
        wr(8'hF5, 8'hC0, 8'h00, 1'b0);
        setAll(14'h3000, 14'h3000, 1'b0);
        chkAll();
    endtask : tBcast
    task automatic tAsync();
        wr(8'h42, 8'h77, 8'h70, 1'b0);
        expT[1] = 14'h0777;
        asyncLoad = 1'b1;
        @(negedge clk_sys);
        @(negedge clk_sys);
        asyncLoad = 1'b0;
        setAll(14'h0, 14'h0, 1'b1);
        chkAll();
    endtask : tAsync
    task automatic tReset();
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        setAll(14'h0, 14'h0, 1'b0);
        chkAll();
        wr(8'h50, 8'h12, 8'h30, 1'b0);
        expT[0] = 14'h0123;
        expD[0] = 14'h0123;
        chkAll();
    endtask : tReset
    initial
    begin
        rst = 1'b1;
        asyncLoad = 1'b0;
        readSel = 2'h0;
        setAll(14'h0, 14'h0, 1'b0);
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        chkAll();
        tLocal();
        tAddr();
        tBcast();
        tAsync();
        tReset();
        stop_test();
    end
endmodule : tb
bind quad_dac_update_control quad_dac_update_control_chk i_chk (
    .clk_sys(clk_sys), .rst(rst), .frameStart(frameStart),
    .frameEnd(frameEnd), .byteStrobe(byteStrobe), .byteData(byteData),
    .ext_addr_pin_hi(ext_addr_pin_hi), .ext_addr_pin_lo(ext_addr_pin_lo),
    .async_load_pin(async_load_pin), .readSel(readSel),
    .readData(readData), .dacOut(dacOut), .tempOut(tempOut),
    .frameActive(frameActive));
`default_nettype wire
